// ### idef_pkg.sv
// Package for the isolated digital I/O event filter: register map, fields, resets, timing.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
package idef_pkg;
	localparam int IDEF_NCH = 8;
	localparam int IDEF_CLK_HZ = 20000000;
	localparam logic [7:0] IDEF_ADDR_INPUT = 8'h00;
	localparam logic [7:0] IDEF_ADDR_OUTPUT = 8'h04;
	localparam logic [7:0] IDEF_ADDR_MODE = 8'h08;
	localparam logic [7:0] IDEF_ADDR_FCTRL = 8'h0C;
	localparam logic [7:0] IDEF_ADDR_FDELAY = 8'h10;
	localparam logic [7:0] IDEF_ADDR_STATUS = 8'h14;
	localparam logic [7:0] IDEF_ADDR_MASK = 8'h18;
	localparam int IDEF_FCTRL_EN_BIT = 0;
	localparam logic [31:0] IDEF_RST_OUTPUT = 32'h0000_0000;
	localparam logic [15:0] IDEF_RST_MODE = 16'h0000;
	localparam logic [31:0] IDEF_RST_MASK = 32'h0000_0000;
	localparam int IDEF_FMIN_NS = 10000;
	localparam longint IDEF_FMAX_NS = 64'd3500000000;
	localparam int IDEF_FREC_NS = 10000000;
	localparam int IDEF_CLK_NS = 1000000000 / IDEF_CLK_HZ;
	localparam int IDEF_FMIN_CYC = (IDEF_FMIN_NS + IDEF_CLK_NS - 1) / IDEF_CLK_NS;
	localparam longint IDEF_FMAX_CYC = IDEF_FMAX_NS / IDEF_CLK_NS;
	localparam int IDEF_FREC_CYC = IDEF_FREC_NS / IDEF_CLK_NS;
	localparam logic [27:0] IDEF_RST_FDELAY = 28'(IDEF_FREC_CYC);
	localparam logic [27:0] IDEF_FDELAY_MIN = 28'(IDEF_FMIN_CYC);
	localparam logic [27:0] IDEF_FDELAY_MAX = 28'(IDEF_FMAX_CYC);
	typedef enum logic [1:0] {
		IDEF_TRIG_FALL = 2'h0,
		IDEF_TRIG_RISE = 2'h1,
		IDEF_TRIG_ANY = 2'h2
	} idef_trig_t;
	typedef struct packed {
		logic [7:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
	} idef_req_t;
endpackage : idef_pkg

// ### idef_top.sv
// Top of the isolated digital I/O event filter: 8 inputs with trigger and glitch filter, 8 sink outputs, APB slave.
// Assumes input pins asynchronous to SYS_CLK and a single 20 MHz clock.
// What this block does
// - All eight input levels sampled together; one reads high, zero reads low.
// - Each input independently selects falling, rising or any-change trigger.
// - A matching accepted transition raises that input's event flag.
// - Glitch filter is off after reset.
// - Filter delay programmable from 10us to 3.5s, 10ms recommended.
// - Filtered edge accepted only if level after delay equals edge level.
// - Filter meant for mechanical switches; keep off for clean sources.
// - Open command turns sink off, close command turns it on.
// - All outputs open from power-up until software closes them.
`timescale 1ns/100ps
`default_nettype none
module idef_top
	import idef_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic [7:0] DIN,
	output logic [7:0] DOUT_CLOSE,
	output logic IRQ,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	idef_req_t req;
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic [7:0] level_reg;
	logic [7:0] out_reg;
	logic [15:0] mode_reg;
	logic fen_reg;
	logic [27:0] fdelay_reg;
	logic [7:0] status_reg;
	logic [7:0] mask_reg;
	logic [7:0] event_set;
	logic wr_en;
	logic rd_en;
	logic addr_ok;

	assign req = '{paddr: PADDR, pwrite: PWRITE, pwdata: PWDATA};
	assign wr_en = PSEL && PENABLE && req.pwrite;
	assign rd_en = PSEL && PENABLE && !req.pwrite;
	always_comb begin
		unique case (req.paddr)
			IDEF_ADDR_INPUT, IDEF_ADDR_OUTPUT, IDEF_ADDR_MODE, IDEF_ADDR_FCTRL,
			IDEF_ADDR_FDELAY, IDEF_ADDR_STATUS, IDEF_ADDR_MASK: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
		end else begin
			sync1_reg <= DIN;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			level_reg <= 8'h00;
		end else begin
			level_reg <= sync2_reg;
		end
	end

	// Per-input edge detection and glitch filter
	genvar gi;
	generate
		for (gi = 0; gi < IDEF_NCH; gi++) begin : g_ch
			logic pend_reg;
			logic edge_lvl_reg;
			logic [27:0] cnt_reg;
			logic rise;
			logic fall;
			logic hit;
			logic prev_lvl;
			idef_trig_t trig;
			assign trig = idef_trig_t'(mode_reg[2*gi +: 2]);
			assign rise = sync2_reg[gi] && !level_reg[gi];
			assign fall = !sync2_reg[gi] && level_reg[gi];
			always_comb begin
				prev_lvl = !edge_lvl_reg;
				unique case (trig)
					IDEF_TRIG_FALL: hit = fen_reg ? (pend_reg && cnt_reg == 28'h000_0000 && !edge_lvl_reg) : fall;
					IDEF_TRIG_RISE: hit = fen_reg ? (pend_reg && cnt_reg == 28'h000_0000 && edge_lvl_reg) : rise;
					IDEF_TRIG_ANY: hit = fen_reg ? (pend_reg && cnt_reg == 28'h000_0000) : (rise || fall);
					default: hit = 1'b0;
				endcase
				// level after delay must equal level at edge
				if (fen_reg && sync2_reg[gi] != edge_lvl_reg) begin
					hit = 1'b0;
				end
				if (prev_lvl == edge_lvl_reg) begin
					hit = 1'b0;
				end
			end
			always_ff @(posedge SYS_CLK or negedge RST_B) begin
				if (!RST_B) begin
					pend_reg <= 1'b0;
					edge_lvl_reg <= 1'b0;
					cnt_reg <= 28'h000_0000;
				end else if (!fen_reg) begin
					pend_reg <= 1'b0;
					cnt_reg <= 28'h000_0000;
				end else if (pend_reg) begin
					if (cnt_reg == 28'h000_0000) begin
						pend_reg <= 1'b0;
					end else begin
						cnt_reg <= cnt_reg - 28'h000_0001;
					end
				end else if (rise || fall) begin
					pend_reg <= 1'b1;
					edge_lvl_reg <= sync2_reg[gi];
					cnt_reg <= fdelay_reg - 28'h000_0001;
				end
			end
			assign event_set[gi] = hit;
		end
	endgenerate

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			out_reg <= IDEF_RST_OUTPUT[7:0];
		end else if (wr_en && req.paddr == IDEF_ADDR_OUTPUT) begin
			out_reg <= req.pwdata[7:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode_reg <= IDEF_RST_MODE;
		end else if (wr_en && req.paddr == IDEF_ADDR_MODE) begin
			mode_reg <= req.pwdata[15:0];
		end
	end

	// filter disabled at reset; software enables only for switches
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			fen_reg <= 1'b0;
		end else if (wr_en && req.paddr == IDEF_ADDR_FCTRL) begin
			fen_reg <= req.pwdata[IDEF_FCTRL_EN_BIT];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			fdelay_reg <= IDEF_RST_FDELAY;
		end else if (wr_en && req.paddr == IDEF_ADDR_FDELAY) begin
			if (req.pwdata[31:28] == 4'h0 && req.pwdata[27:0] < IDEF_FDELAY_MIN) begin
				fdelay_reg <= IDEF_FDELAY_MIN;
			end else if (req.pwdata[31:28] != 4'h0 || req.pwdata[27:0] > IDEF_FDELAY_MAX) begin
				fdelay_reg <= IDEF_FDELAY_MAX;
			end else begin
				fdelay_reg <= req.pwdata[27:0];
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mask_reg <= IDEF_RST_MASK[7:0];
		end else if (wr_en && req.paddr == IDEF_ADDR_MASK) begin
			mask_reg <= req.pwdata[7:0];
		end
	end

	// sticky event flags, set wins over write-one-clear
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			status_reg <= 8'h00;
		end else if (wr_en && req.paddr == IDEF_ADDR_STATUS) begin
			status_reg <= (status_reg & ~req.pwdata[7:0]) | event_set;
		end else begin
			status_reg <= status_reg | event_set;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			IRQ <= 1'b0;
			DOUT_CLOSE <= 8'h00;
		end else begin
			IRQ <= |(status_reg & mask_reg);
			DOUT_CLOSE <= out_reg;
		end
	end

	// Zero-wait APB answer; unmapped addresses error and read zero
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !addr_ok;
			PRDATA <= 32'h0000_0000;
			if (PSEL && !PENABLE && !req.pwrite) begin
				unique case (req.paddr)
					IDEF_ADDR_INPUT: PRDATA <= {24'h00_0000, level_reg};
					IDEF_ADDR_OUTPUT: PRDATA <= {24'h00_0000, out_reg};
					IDEF_ADDR_MODE: PRDATA <= {16'h0000, mode_reg};
					IDEF_ADDR_FCTRL: PRDATA <= {31'h0000_0000, fen_reg};
					IDEF_ADDR_FDELAY: PRDATA <= {4'h0, fdelay_reg};
					IDEF_ADDR_STATUS: PRDATA <= {24'h00_0000, status_reg};
					IDEF_ADDR_MASK: PRDATA <= {24'h00_0000, mask_reg};
					default: PRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : idef_top
`default_nettype wire

// ### idef_top_props.sv
// Checker for the digital I/O event block, bound to its top module.
// Sees only the top ports; one clock domain with async low reset.
`timescale 1ns/100ps
`default_nettype none
module idef_top_chk
	import idef_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic [7:0] DIN,
	input wire logic [7:0] DOUT_CLOSE,
	input wire logic IRQ,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	chk_ready_access: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
	chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
	chk_ready_only: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
	chk_err_unmapped: assert property (PREADY && PADDR > IDEF_ADDR_MASK |-> PSLVERR && PRDATA == 32'h0000_0000)
		else $error("unmapped access not refused");
	chk_out_reset: assert property ($rose(RST_B) |-> DOUT_CLOSE == 8'h00 && !IRQ) else $error("outputs not open");
	chk_out_write: assert property (PSEL && PENABLE && PWRITE && PADDR == IDEF_ADDR_OUTPUT
		|-> ##2 DOUT_CLOSE == $past(PWDATA[7:0], 2)) else $error("output switch mismatch");
	chk_out_hold: assert property (!(PSEL && PENABLE && PWRITE && PADDR == IDEF_ADDR_OUTPUT)
		|-> ##2 $stable(DOUT_CLOSE)) else $error("output moved without command");
	chk_in_read: assert property ($stable(DIN) [*6] ##1 (PREADY && !PWRITE && PADDR == IDEF_ADDR_INPUT)
		|-> PRDATA == {24'h00_0000, $past(DIN, 4)}) else $error("input byte mismatch");
	chk_irq_sticky: assert property ($fell(IRQ) |-> $past(PENABLE, 2) && $past(PWRITE, 2))
		else $error("interrupt dropped without a write");
endmodule : idef_top_chk
bind idef_top idef_top_chk idef_top_chk_inst (.SYS_CLK, .RST_B, .DIN, .DOUT_CLOSE, .IRQ, .PSEL, .PENABLE,
	.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
`default_nettype wire

// ### idef_pins.sv
// Model of the field side: sensors and contacts that may chatter.
// Assumes the level command changes only at rising clock edges.
`timescale 1ns/100ps
`default_nettype none
module idef_pins (
	input wire logic clk,
	input wire logic [7:0] lvl,
	input wire logic [7:0] bnc,
	output logic [7:0] pin
);
	logic [7:0] lvl_reg = 8'h00;
	logic [5:0] cnt_reg = 6'h28;
	always_ff @(posedge clk) begin
		lvl_reg <= lvl;
		if (lvl != lvl_reg) begin
			cnt_reg <= 6'h00;
		end else if (cnt_reg != 6'h28) begin
			cnt_reg <= cnt_reg + 6'h01;
		end
	end
	// Chosen contacts flip in 8-cycle bursts for 40 cycles after any change
	assign pin = (cnt_reg != 6'h28 && cnt_reg[3]) ? lvl_reg ^ bnc : lvl_reg;
endmodule : idef_pins
`default_nettype wire

// ### tb.sv
// Self-checking bench: APB tasks reach the registers, a contact model drives the pins.
// Assumes the package, design, checker and pin model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb
	import idef_pkg::*;
;
	logic SYS_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, IRQ, PREADY, PSLVERR;
	logic [7:0] PADDR = 8'h00, lvl = 8'h00, bnc = 8'h00, DIN, DOUT_CLOSE;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rdata;
	logic rerr;
	int err_count = 0, n_compared = 0, cyc = 0;
	always #25 SYS_CLK = ~SYS_CLK;
	idef_top idef_top_inst (.SYS_CLK, .RST_B, .DIN, .DOUT_CLOSE, .IRQ, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR);
	idef_pins idef_pins_inst (.clk(SYS_CLK), .lvl, .bnc, .pin(DIN));
	task automatic wrap_up;
		if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	// Ready, read data and error are taken at the rising edge that ends the access
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		rdata = PRDATA;
		rerr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, e, rdata)
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (5) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		rd(IDEF_ADDR_OUTPUT, 32'h0000_0000, "output");
		`CHK("dout", 8'h00, DOUT_CLOSE)
		rd(IDEF_ADDR_FCTRL, 32'h0000_0000, "fctrl");
		rd(IDEF_ADDR_FDELAY, 32'h0003_0D40, "fdelay");
		lvl <= 8'hA5;
		repeat (6) @(posedge SYS_CLK);
		rd(IDEF_ADDR_INPUT, 32'h0000_00A5, "input");
		wr(IDEF_ADDR_OUTPUT, 32'h0000_005A);
		@(posedge SYS_CLK);
		@(negedge SYS_CLK);
		`CHK("dout", 8'h5A, DOUT_CLOSE)
		@(posedge SYS_CLK);
		lvl <= 8'h00;
		repeat (6) @(posedge SYS_CLK);
		rd(IDEF_ADDR_STATUS, 32'h0000_00A5, "fall");
		wr(IDEF_ADDR_STATUS, 32'h0000_00FF);
		rd(IDEF_ADDR_STATUS, 32'h0000_0000, "clear");
		wr(IDEF_ADDR_MODE, 32'h0000_00E4);
		wr(IDEF_ADDR_MASK, 32'h0000_00FF);
		lvl <= 8'hFF;
		repeat (6) @(posedge SYS_CLK);
		rd(IDEF_ADDR_STATUS, 32'h0000_0006, "rise");
		`CHK("irq", 1'b1, IRQ)
		lvl <= 8'h00;
		repeat (6) @(posedge SYS_CLK);
		rd(IDEF_ADDR_STATUS, 32'h0000_00F7, "modes");
		wr(IDEF_ADDR_MASK, 32'h0000_0000);
		@(posedge SYS_CLK);
		@(negedge SYS_CLK);
		`CHK("irq", 1'b0, IRQ)
		wr(IDEF_ADDR_STATUS, 32'h0000_00FF);
		wr(IDEF_ADDR_MODE, 32'h0000_AAAA);
		wr(IDEF_ADDR_FDELAY, 32'h0000_00C8);
		wr(IDEF_ADDR_FCTRL, 32'h0000_0001);
		bnc <= 8'h02;
		lvl <= 8'h03;
		repeat (20) @(posedge SYS_CLK);
		lvl <= 8'h02;
		repeat (100) @(posedge SYS_CLK);
		rd(IDEF_ADDR_STATUS, 32'h0000_0000, "pending");
		repeat (150) @(posedge SYS_CLK);
		rd(IDEF_ADDR_STATUS, 32'h0000_0002, "filtered");
		rd(8'h40, 32'h0000_0000, "unmapped");
		`CHK("slverr", 1'b1, rerr)
		wrap_up();
	end
endmodule : tb
`default_nettype wire
